// ---- rtl/eim_pkg.sv ----
/*
 * Shared constants and types of the enclave instruction mode checker:
 * register map, field positions, reset values, leaf codes, request and
 * answer layouts.
 * Assumes the core's decode and address units fill in the request flags.
 */
package eim_pkg;

    // ==================================================================
    // Register map (byte addresses) and field positions
    localparam logic [7:0]  ADDR_FEATCTL  = 8'h00;
    localparam logic [7:0]  ADDR_VMCTRL   = 8'h04;
    localparam logic [7:0]  ADDR_BMP_LO   = 8'h08;
    localparam logic [7:0]  ADDR_BMP_HI   = 8'h0c;
    localparam logic [7:0]  ADDR_STATUS   = 8'h10;
    localparam int          FEAT_LOCK_BIT = 0;
    localparam int          FEAT_EN_BIT   = 18;
    localparam int          VM_EXIT_BIT   = 0;
    localparam int          VM_VAPIC_BIT  = 1;
    localparam logic [31:0] FEATCTL_RST   = 32'h0000_0000;
    localparam logic [31:0] VMCTRL_RST    = 32'h0000_0000;
    localparam logic [63:0] BMP_RST       = 64'h0000_0000_0000_0000;

    // ==================================================================
    // Leaf numbers and privilege levels
    localparam logic [5:0]  LEAF_ENTER    = 6'h02;
    localparam logic [5:0]  LEAF_RESUME   = 6'h03;
    localparam logic [5:0]  LEAF_EXIT     = 6'h04;
    localparam logic [5:0]  LEAF_DBG_RD   = 6'h04;
    localparam logic [5:0]  LEAF_DBG_WR   = 6'h05;
    localparam logic [1:0]  CPL_USER      = 2'h3;
    localparam logic [1:0]  CPL_SUPER     = 2'h0;

    // ==================================================================
    // Types
    typedef enum logic [2:0] {
        K_USER   = 3'b000,
        K_SUPER  = 3'b001,
        K_SEGWR  = 3'b010,
        K_WRBASE = 3'b011,
        K_FETCH  = 3'b100,
        K_ACCESS = 3'b101,
        K_AEX    = 3'b110
    } eim_kind_t;

    typedef enum logic [2:0] {
        F_NONE      = 3'b000,
        F_UD        = 3'b001,
        F_GP0       = 3'b010,
        F_PF        = 3'b011,
        F_VMX_SUPERVISOR_ENCLAVE_OP = 3'b100,
        F_VMX_APIC  = 3'b101
    } eim_fault_t;

    typedef struct packed {
        eim_kind_t   kind;
        logic [5:0]  leaf;
        logic [63:0] data;
        logic        pfx_opsize;
        logic        pfx_addrsize;
        logic        pfx_segovr;
        logic        prot;
        logic        smm;
        logic        v86;
        logic        paging;
        logic        long64;
        logic        addr16;
        logic        cs_d;
        logic [1:0]  cpl;
        logic        guest;
        logic        ds_usable;
        logic        ds_expdown;
        logic        seg_base_nz;
        logic        cs_wide_mode_attribute;
        logic        fsgs_in_ds;
        logic        implicit_acc;
        logic        explicit_enc;
        logic        apic_overlap;
        logic        vapic_redirect;
        logic        in_enclave_linear_range;
        logic        epc_nofault;
    } eim_req_t;

    typedef struct packed {
        logic [63:0] base;
        logic [31:0] limit;
        logic [11:0] attr;
    } eim_seg_t;

    typedef struct packed {
        logic [63:0] fs_ofs;
        logic [63:0] gs_ofs;
        logic [31:0] fs_limit;
        logic [31:0] gs_limit;
        logic [63:0] encl_base;
        logic        encl_wide_mode_attribute;
        logic [63:0] ssa_fs_base;
        logic [63:0] ssa_gs_base;
    } eim_encl_t;

    typedef struct packed {
        eim_fault_t fault;
        logic       addr_w64;
        logic       seg_ds;
        logic       ad_allow;
    } eim_resp_t;

endpackage

// ---- rtl/eim_top.sv ----
/*
 * Enclave instruction legality and exception checker, one answer per
 * request, one cycle after it; holds FS/GS state across enclave entry
 * and exit, and the feature and exiting controls behind an APB slave.
 * Assumes requests are synchronous to clk_i and that the core's address
 * unit supplies the range and overlap flags of each request.
 */
// The register offsets and the APB register port were left to the implementer.
// How it works
// - Memory operands use DS; overrides ignored
// - Operand-size prefix raises invalid opcode fault
// - Address width follows mode, prefix ignored
// - Sixteen-bit addressing uses 32-bit addresses
// - DS unusable or expand-down gives GP0
// - Entry needs zero bases except FS, GS
// - Entry saves FS/GS, loads from thread struct
// - New FS/GS must lie within DS
// - Entry needs matching code mode, CPL 3
// - Exit or async exit restores saved FS/GS
// - Segment changes inside enclave fault, except base writes in a 64-bit enclave
// - Enter loads FS/GS from offsets plus base
// - Base writes saved on async exit, resumed
// - Paging off faults, except debug leaves
// - Accessed/dirty may set on non-faulting accesses
// - Exiting control off permits all supervisor leaves
// - Exiting bitmap bit per leaf forces exit
// - Bitmap exit checked right after CPL check
// - Implicit accesses skip APIC page checks
// - Explicit access on APIC page gives page fault
// - Redirected non-enclave access gives APIC exit
// - Fetch outside enclave range gives GP0
// - Only protected mode, not SMM or V86
// - Needs feature enable and lock bits
`timescale 1ns/1ps
`default_nettype none

module eim_top
(
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // APB slave
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic [7:0]         paddr_i,
    input  wire logic [31:0]        pwdata_i,
    input  wire logic [3:0]         pstrb_i,
    output logic [31:0]             prdata_o,
    output logic                    pready_o,
    output logic                    pslverr_o,
    // Check request
    input  wire logic               req_valid_i,
    input  var  eim_pkg::eim_req_t  req_i,
    input  var  eim_pkg::eim_encl_t encl_i,
    input  var  eim_pkg::eim_seg_t  fs_load_i,
    input  var  eim_pkg::eim_seg_t  gs_load_i,
    // Answer and state
    output logic                    resp_valid_o,
    output eim_pkg::eim_resp_t      resp_o,
    output eim_pkg::eim_seg_t       fs_o,
    output eim_pkg::eim_seg_t       gs_o,
    output logic                    in_enclave_o,
    output logic                    ssa_wr_o,
    output logic [63:0]             ssa_fs_base_o,
    output logic [63:0]             ssa_gs_base_o
);

    // ==================================================================
    // Registers
    logic [31:0]            featctl_q;
    logic [31:0]            vmctrl_q;
    logic [63:0]            bmp_q;
    logic                   pready_q;
    logic                   pslverr_q;
    logic [31:0]            prdata_q;
    logic                   resp_valid_q;
    eim_pkg::eim_resp_t     resp_q;
    eim_pkg::eim_fault_t    last_fault_q;
    logic                   in_encl_q;
    logic                   encl64_q;
    eim_pkg::eim_seg_t      fs_q;
    eim_pkg::eim_seg_t      gs_q;
    eim_pkg::eim_seg_t      fs_sav_q;
    eim_pkg::eim_seg_t      gs_sav_q;
    logic                   ssa_wr_q;
    logic [63:0]            ssa_fs_q;
    logic [63:0]            ssa_gs_q;

    // ==================================================================
    // APB decode
    logic        setup_w;
    logic        wr_w;
    logic        hit_feat;
    logic        hit_vm;
    logic        hit_lo;
    logic        hit_hi;
    logic        hit_st;
    logic        mapped_w;
    logic [31:0] wmask_w;
    logic [31:0] rdata_w;
    logic [31:0] status_w;
    logic        feat_lock_w;

    // Address decode and byte-lane mask
    assign setup_w     = psel_i & ~penable_i;
    assign wr_w        = psel_i & penable_i & pready_q & pwrite_i & ~pslverr_q;
    assign hit_feat    = paddr_i == eim_pkg::ADDR_FEATCTL;
    assign hit_vm      = paddr_i == eim_pkg::ADDR_VMCTRL;
    assign hit_lo      = paddr_i == eim_pkg::ADDR_BMP_LO;
    assign hit_hi      = paddr_i == eim_pkg::ADDR_BMP_HI;
    assign hit_st      = paddr_i == eim_pkg::ADDR_STATUS;
    assign mapped_w    = hit_feat | hit_vm | hit_lo | hit_hi | hit_st;
    assign wmask_w     = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
    assign feat_lock_w = featctl_q[eim_pkg::FEAT_LOCK_BIT];
    assign status_w    = {26'h0, last_fault_q, encl64_q, in_encl_q, 1'b0} | {31'h0, 1'b0};
    assign rdata_w     = hit_feat ? featctl_q :
                         hit_vm   ? vmctrl_q :
                         hit_lo   ? bmp_q[31:0] :
                         hit_hi   ? bmp_q[63:32] :
                         hit_st   ? status_w : 32'h0;

    // Answer prepared in setup, ready in the first access cycle
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end
        else
        begin
            pready_q  <= setup_w;
            pslverr_q <= setup_w & ~mapped_w;
            prdata_q  <= (setup_w & ~pwrite_i) ? rdata_w : 32'h0;
        end
    end

    // Control writes; feature control freezes once locked
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            featctl_q <= eim_pkg::FEATCTL_RST;
            vmctrl_q  <= eim_pkg::VMCTRL_RST;
            bmp_q     <= eim_pkg::BMP_RST;
        end
        else if (wr_w)
        begin
            if (hit_feat && !feat_lock_w)
                featctl_q <= (featctl_q & ~wmask_w) | (pwdata_i & wmask_w);
            if (hit_vm)
                vmctrl_q <= (vmctrl_q & ~wmask_w) | (pwdata_i & wmask_w);
            if (hit_lo)
                bmp_q[31:0] <= (bmp_q[31:0] & ~wmask_w) | (pwdata_i & wmask_w);
            if (hit_hi)
                bmp_q[63:32] <= (bmp_q[63:32] & ~wmask_w) | (pwdata_i & wmask_w);
        end
    end

    // ==================================================================
    // Check conditions
    logic                is_user;
    logic                is_super;
    logic                is_insn;
    logic                avail_w;
    logic                dbg_leaf;
    logic                enter_w;
    logic                resume_w;
    logic                exit_w;
    logic                entry_bad;
    logic                vapic_w;
    logic                acc_w;
    eim_pkg::eim_fault_t fault_w;
    logic                ok_w;
    logic                go_entry;
    logic                go_exit;
    logic                go_aex;
    logic                go_wrbase;

    // Request classification
    assign is_user  = req_i.kind == eim_pkg::K_USER;
    assign is_super = req_i.kind == eim_pkg::K_SUPER;
    assign is_insn  = is_user | is_super;
    assign avail_w  = req_i.prot & ~req_i.smm & ~req_i.v86
                    & featctl_q[eim_pkg::FEAT_EN_BIT] & feat_lock_w;
    assign dbg_leaf = is_super & (req_i.leaf == eim_pkg::LEAF_DBG_RD
                                | req_i.leaf == eim_pkg::LEAF_DBG_WR);
    assign enter_w  = is_user & (req_i.leaf == eim_pkg::LEAF_ENTER);
    assign resume_w = is_user & (req_i.leaf == eim_pkg::LEAF_RESUME);
    assign exit_w   = is_user & (req_i.leaf == eim_pkg::LEAF_EXIT);
    assign vapic_w  = vmctrl_q[eim_pkg::VM_VAPIC_BIT];
    assign acc_w    = req_i.kind == eim_pkg::K_ACCESS & vapic_w & ~req_i.implicit_acc;

    // Entry preconditions
    assign entry_bad = (enter_w | resume_w)
                     & (in_encl_q
                      | req_i.seg_base_nz
                      | ~req_i.fsgs_in_ds
                      | req_i.cpl != eim_pkg::CPL_USER
                      | req_i.cs_wide_mode_attribute != encl_i.encl_wide_mode_attribute);

    // Fixed priority, first match wins
    assign fault_w =
        (is_insn & ~avail_w)                                  ? eim_pkg::F_UD :
        (is_insn & req_i.pfx_opsize)                          ? eim_pkg::F_UD :
        (is_insn & ~req_i.paging & ~dbg_leaf)                 ? eim_pkg::F_UD :
        (req_i.kind == eim_pkg::K_SEGWR & in_encl_q)          ? eim_pkg::F_UD :
        (req_i.kind == eim_pkg::K_WRBASE & in_encl_q & ~encl64_q) ? eim_pkg::F_UD :
        (is_super & req_i.cpl != eim_pkg::CPL_SUPER)          ? eim_pkg::F_GP0 :
        (is_super & req_i.guest & vmctrl_q[eim_pkg::VM_EXIT_BIT]
                  & bmp_q[req_i.leaf])                        ? eim_pkg::F_VMX_SUPERVISOR_ENCLAVE_OP :
        (is_insn & (~req_i.ds_usable | req_i.ds_expdown))     ? eim_pkg::F_GP0 :
        entry_bad                                             ? eim_pkg::F_GP0 :
        (req_i.kind == eim_pkg::K_FETCH & in_encl_q & ~req_i.in_enclave_linear_range)
                                                              ? eim_pkg::F_GP0 :
        (acc_w & req_i.explicit_enc & req_i.apic_overlap)     ? eim_pkg::F_PF :
        (acc_w & ~req_i.explicit_enc & req_i.vapic_redirect)  ? eim_pkg::F_VMX_APIC :
                                                                eim_pkg::F_NONE;

    // State changes only on a clean request
    assign ok_w       = req_valid_i & (fault_w == eim_pkg::F_NONE);
    assign go_entry   = ok_w & (enter_w | resume_w);
    assign go_exit    = ok_w & exit_w & in_encl_q;
    assign go_aex     = ok_w & (req_i.kind == eim_pkg::K_AEX) & in_encl_q;
    assign go_wrbase  = ok_w & (req_i.kind == eim_pkg::K_WRBASE);

    // ==================================================================
    // Answer register
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            resp_valid_q <= 1'b0;
            resp_q       <= '0;
            last_fault_q <= eim_pkg::F_NONE;
        end
        else
        begin
            resp_valid_q      <= req_valid_i;
            resp_q.fault      <= req_valid_i ? fault_w : eim_pkg::F_NONE;
            resp_q.addr_w64   <= req_valid_i & req_i.long64;
            resp_q.seg_ds     <= req_valid_i;
            resp_q.ad_allow   <= req_valid_i & req_i.epc_nofault;
            if (req_valid_i)
                last_fault_q <= fault_w;
        end
    end

    // ==================================================================
    // FS/GS state across entry and exit
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            in_encl_q <= 1'b0;
            encl64_q  <= 1'b0;
            fs_q      <= '0;
            gs_q      <= '0;
            fs_sav_q  <= '0;
            gs_sav_q  <= '0;
            ssa_wr_q  <= 1'b0;
            ssa_fs_q  <= 64'h0;
            ssa_gs_q  <= 64'h0;
        end
        else
        begin
            ssa_wr_q <= go_aex;
            if (go_entry)
            begin
                fs_sav_q       <= fs_q;
                gs_sav_q       <= gs_q;
                in_encl_q      <= 1'b1;
                encl64_q       <= encl_i.encl_wide_mode_attribute;
                fs_q.attr      <= fs_load_i.attr;
                gs_q.attr      <= gs_load_i.attr;
                fs_q.limit     <= encl_i.fs_limit;
                gs_q.limit     <= encl_i.gs_limit;
                fs_q.base      <= (resume_w & encl_i.encl_wide_mode_attribute) ? encl_i.ssa_fs_base
                                  : encl_i.fs_ofs + encl_i.encl_base;
                gs_q.base      <= (resume_w & encl_i.encl_wide_mode_attribute) ? encl_i.ssa_gs_base
                                  : encl_i.gs_ofs + encl_i.encl_base;
            end
            else if (go_exit || go_aex)
            begin
                fs_q      <= fs_sav_q;
                gs_q      <= gs_sav_q;
                in_encl_q <= 1'b0;
                encl64_q  <= 1'b0;
                if (go_aex)
                begin
                    ssa_fs_q <= fs_q.base;
                    ssa_gs_q <= gs_q.base;
                end
            end
            else if (go_wrbase)
            begin
                if (req_i.leaf[0])
                    gs_q.base <= req_i.data;
                else
                    fs_q.base <= req_i.data;
            end
        end
    end

    // Outputs straight from flops
    assign prdata_o      = prdata_q;
    assign pready_o      = pready_q;
    assign pslverr_o     = pslverr_q;
    assign resp_valid_o  = resp_valid_q;
    assign resp_o        = resp_q;
    assign fs_o          = fs_q;
    assign gs_o          = gs_q;
    assign in_enclave_o  = in_encl_q;
    assign ssa_wr_o      = ssa_wr_q;
    assign ssa_fs_base_o = ssa_fs_q;
    assign ssa_gs_base_o = ssa_gs_q;

    // ==================================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_seg_ds;
        req_valid_i |=> resp_valid_o && resp_o.seg_ds;
    endproperty
    a_seg_ds: assert property (p_seg_ds) else $error("operand segment not DS");

    property p_opsize;
        req_valid_i && is_insn && avail_w && req_i.pfx_opsize |=> resp_o.fault == eim_pkg::F_UD;
    endproperty
    a_opsize: assert property (p_opsize) else $error("opsize prefix not faulted");

    property p_addrw;
        req_valid_i |=> resp_o.addr_w64 == $past(req_i.long64);
    endproperty
    a_addrw: assert property (p_addrw) else $error("address width wrong");

    property p_ds;
        req_valid_i && is_user && avail_w && !req_i.pfx_opsize && req_i.paging
        && !req_i.ds_usable |=> resp_o.fault == eim_pkg::F_GP0;
    endproperty
    a_ds: assert property (p_ds) else $error("unusable DS not faulted");

    property p_enter;
        go_entry && enter_w |=> fs_o.base == $past(encl_i.fs_ofs) + $past(encl_i.encl_base)
                                && in_enclave_o && fs_sav_q == $past(fs_q);
    endproperty
    a_enter: assert property (p_enter) else $error("FS not loaded on enter");

    property p_restore;
        go_exit |=> fs_o == $past(fs_sav_q) && gs_o == $past(gs_sav_q) && !in_enclave_o;
    endproperty
    a_restore: assert property (p_restore) else $error("FS/GS not restored");

    property p_segwr;
        req_valid_i && req_i.kind == eim_pkg::K_SEGWR && in_encl_q
        |=> resp_o.fault == eim_pkg::F_UD;
    endproperty
    a_segwr: assert property (p_segwr) else $error("segment write allowed");

    property p_paging;
        req_valid_i && is_user && avail_w && !req_i.pfx_opsize && !req_i.paging
        |=> resp_o.fault == eim_pkg::F_UD;
    endproperty
    a_paging: assert property (p_paging) else $error("paging off not faulted");

    property p_bmp;
        req_valid_i && is_super && avail_w && !req_i.pfx_opsize && req_i.paging
        && req_i.cpl == eim_pkg::CPL_SUPER && req_i.guest
        |=> (resp_o.fault == eim_pkg::F_VMX_SUPERVISOR_ENCLAVE_OP)
            == $past(vmctrl_q[eim_pkg::VM_EXIT_BIT] && bmp_q[req_i.leaf]);
    endproperty
    a_bmp: assert property (p_bmp) else $error("bitmap exit wrong");

    property p_fetch;
        req_valid_i && req_i.kind == eim_pkg::K_FETCH && in_encl_q && !req_i.in_enclave_linear_range
        |=> resp_o.fault == eim_pkg::F_GP0;
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch outside range");

    property p_implicit;
        req_valid_i && req_i.kind == eim_pkg::K_ACCESS && req_i.implicit_acc
        |=> resp_o.fault == eim_pkg::F_NONE;
    endproperty
    a_implicit: assert property (p_implicit) else $error("implicit access faulted");

    property p_aex;
        go_aex |=> ssa_wr_o && ssa_fs_base_o == $past(fs_q.base) ##1 !ssa_wr_o;
    endproperty
    a_aex: assert property (p_aex) else $error("bases not saved on async exit");

    c_enter: cover property (go_entry ##[1:20] go_aex);
    c_exit: cover property (go_entry ##[1:20] go_exit);
    c_vmx: cover property (resp_valid_o && resp_o.fault == eim_pkg::F_VMX_SUPERVISOR_ENCLAVE_OP);

endmodule

`default_nettype wire

// ---- tb/eim_sw_model.sv ----
/*
 * Software and hypervisor side: APB master for the controls and a
 * request source for the checker. Assumes one clock, rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module eim_sw_model
(
    input  wire logic         clk_i,
    output logic              psel_o,
    output logic              penable_o,
    output logic              pwrite_o,
    output logic [7:0]        paddr_o,
    output logic [31:0]       pwdata_o,
    input  wire logic [31:0]  prdata_i,
    input  wire logic         pready_i,
    input  wire logic         pslverr_i,
    output logic              req_valid_o,
    output eim_pkg::eim_req_t req_o
);
    // ==========================================
    // Idle levels from time zero
    initial
    begin
        {psel_o, penable_o, pwrite_o, req_valid_o} = 4'h0;
        paddr_o = 8'h00;
        pwdata_o = 32'h0;
        req_o = '0;
    end
    // Hypervisor control access; released lines show inverted data
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clk_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        // Wait for pready_i; only the bench timeout ends a wait that never sees it
        do
        begin
            @(posedge clk_i);
        end
        while (pready_i !== 1'b1);
        q = prdata_i;
        e = pslverr_i;
        {psel_o, penable_o} <= 2'h0;
        paddr_o <= ~a;
        pwdata_o <= ~d;
    endtask
    // One request pulse, then scrambled fields
    task automatic issue(input eim_pkg::eim_req_t r);
        @(posedge clk_i);
        req_valid_o <= 1'b1;
        req_o <= r;
        @(posedge clk_i);
        req_valid_o <= 1'b0;
        req_o <= eim_pkg::eim_req_t'(~r);
    endtask
endmodule
`default_nettype wire

// ---- tb/enclave_insn_mode_checks_tb_top.sv ----
/*
 * Self-checking bench of the enclave mode checker.
 * Assumes the software model above drives APB and requests.
 */
`timescale 1ns/1ps
`default_nettype none
module enclave_insn_mode_checks_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel, pen, pwr, prdy, perr, rv, e;
    logic [7:0] pa;
    logic [31:0] pwd, prd, q;
    eim_pkg::eim_req_t rqs, r;
    eim_pkg::eim_encl_t encl;
    eim_pkg::eim_seg_t sl = '0;
    eim_pkg::eim_resp_t rsp;
    eim_pkg::eim_seg_t fs, gs;
    logic inenc, ssw, rvo;
    logic [63:0] sfs, sgs;
    int fail_count = 0;
    int comparisons = 0;
    int cyc = 0;
    // ==========================================
    // Clock, timeout
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fail_count++;
            test_done();
        end
    end
    eim_sw_model i_eim_sw_model (.clk_i(clk_i), .psel_o(psel), .penable_o(pen),
        .pwrite_o(pwr), .paddr_o(pa), .pwdata_o(pwd), .prdata_i(prd), .pready_i(prdy),
        .pslverr_i(perr), .req_valid_o(rv), .req_o(rqs));
    eim_top i_eim_top (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .pstrb_i(4'hf), .prdata_o(prd),
        .pready_o(prdy), .pslverr_o(perr), .req_valid_i(rv), .req_i(rqs), .encl_i(encl),
        .fs_load_i(sl), .gs_load_i(sl), .resp_valid_o(rvo), .resp_o(rsp), .fs_o(fs),
        .gs_o(gs), .in_enclave_o(inenc), .ssa_wr_o(ssw), .ssa_fs_base_o(sfs),
        .ssa_gs_base_o(sgs));
    // ==========================================
    // Shared helpers
    task automatic chk(input logic [159:0] g, input logic [159:0] x);
        comparisons++;
        if (g !== x)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic rq(input eim_pkg::eim_req_t t, input eim_pkg::eim_fault_t f);
        i_eim_sw_model.issue(t);
        #1;
        chk(rvo, 1'b1);
        chk(rsp.fault, f);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_eim_sw_model.apb(1'b1, a, d, q, e);
    endtask
    function automatic eim_pkg::eim_req_t br(input eim_pkg::eim_kind_t k,
                                             input logic [5:0] l);
        eim_pkg::eim_req_t t;
        t = '0;
        t.kind = k;
        t.leaf = l;
        t.cpl = eim_pkg::CPL_USER;
        {t.prot, t.paging, t.long64, t.ds_usable, t.fsgs_in_ds, t.cs_wide_mode_attribute} = 6'h3f;
        return t;
    endfunction
    // ==========================================
    // Scenarios
    task automatic t_feat();
        rq(br(eim_pkg::K_USER, eim_pkg::LEAF_ENTER), eim_pkg::F_UD);
        i_eim_sw_model.apb(1'b0, 8'h14, 32'h0, q, e);
        chk(e, 1'b1);
        wr(eim_pkg::ADDR_FEATCTL, 32'h0004_0001);
        wr(eim_pkg::ADDR_FEATCTL, 32'h0);
        i_eim_sw_model.apb(1'b0, eim_pkg::ADDR_FEATCTL, 32'h0, q, e);
        chk(q, 32'h0004_0001);
    endtask
    task automatic t_pfx();
        r = br(eim_pkg::K_USER, eim_pkg::LEAF_EXIT);
        r.pfx_opsize = 1'b1;
        rq(r, eim_pkg::F_UD);
        {r.pfx_opsize, r.pfx_addrsize, r.pfx_segovr} = 3'h3;
        rq(r, eim_pkg::F_NONE);
        chk({rsp.addr_w64, rsp.seg_ds}, 2'h3);
        {r.long64, r.addr16, r.cs_d} = 3'h3;
        rq(r, eim_pkg::F_NONE);
        chk(rsp.addr_w64, 1'b0);
        for (int i = 0; i < 6; i++)
        begin
            r = br(eim_pkg::K_USER, eim_pkg::LEAF_EXIT);
            {r.smm, r.v86, r.prot, r.paging} = {i == 0, i == 1, i != 2, i != 3};
            r.ds_usable = (i != 4);
            r.ds_expdown = (i == 5);
            rq(r, i < 4 ? eim_pkg::F_UD : eim_pkg::F_GP0);
        end
        r = br(eim_pkg::K_SUPER, eim_pkg::LEAF_DBG_RD);
        {r.cpl, r.paging} = 3'h0;
        rq(r, eim_pkg::F_NONE);
    endtask
    task automatic t_encl();
        for (int i = 0; i < 4; i++)
        begin
            r = br(eim_pkg::K_USER, eim_pkg::LEAF_ENTER);
            {r.seg_base_nz, r.fsgs_in_ds, r.cs_wide_mode_attribute} = {i == 0, i != 1, i != 3};
            r.cpl = (i == 2) ? 2'h2 : eim_pkg::CPL_USER;
            rq(r, eim_pkg::F_GP0);
            chk(inenc, 1'b0);
        end
        rq(br(eim_pkg::K_USER, eim_pkg::LEAF_ENTER), eim_pkg::F_NONE);
        chk({fs.base, gs.base, fs.limit}, {64'h1100, 64'h1200, 32'hfff});
        rq(br(eim_pkg::K_SEGWR, 6'h00), eim_pkg::F_UD);
        r = br(eim_pkg::K_WRBASE, 6'h00);
        r.data = 64'h7000;
        rq(r, eim_pkg::F_NONE);
        rq(br(eim_pkg::K_FETCH, 6'h00), eim_pkg::F_GP0);
        rq(br(eim_pkg::K_AEX, 6'h00), eim_pkg::F_NONE);
        chk({ssw, sfs, fs.base, inenc}, {1'b1, 64'h7000, 64'h0, 1'b0});
        chk(sgs, 64'h1200);
        rq(br(eim_pkg::K_USER, eim_pkg::LEAF_RESUME), eim_pkg::F_NONE);
        chk(fs.base, 64'h5000);
        rq(br(eim_pkg::K_USER, eim_pkg::LEAF_EXIT), eim_pkg::F_NONE);
        chk({fs.base, inenc}, 65'h0);
    endtask
    task automatic t_vm();
        r = br(eim_pkg::K_SUPER, 6'h05);
        {r.cpl, r.guest} = 3'h1;
        rq(r, eim_pkg::F_NONE);
        wr(eim_pkg::ADDR_VMCTRL, 32'h1);
        wr(eim_pkg::ADDR_BMP_LO, 32'h20);
        wr(eim_pkg::ADDR_BMP_HI, 32'h2);
        rq(r, eim_pkg::F_VMX_SUPERVISOR_ENCLAVE_OP);
        r.ds_usable = 1'b0;
        rq(r, eim_pkg::F_VMX_SUPERVISOR_ENCLAVE_OP);
        r.cpl = 2'h3;
        rq(r, eim_pkg::F_GP0);
        {r.leaf, r.cpl, r.ds_usable} = {6'h21, 2'h0, 1'b1};
        rq(r, eim_pkg::F_VMX_SUPERVISOR_ENCLAVE_OP);
        r.leaf = 6'h06;
        rq(r, eim_pkg::F_NONE);
        wr(eim_pkg::ADDR_VMCTRL, 32'h2);
        // Exiting off while the bitmap still marks this leaf
        r.leaf = 6'h05;
        rq(r, eim_pkg::F_NONE);
        r = br(eim_pkg::K_ACCESS, 6'h00);
        {r.explicit_enc, r.apic_overlap} = 2'h3;
        rq(r, eim_pkg::F_PF);
        {r.explicit_enc, r.implicit_acc, r.epc_nofault} = 3'h3;
        rq(r, eim_pkg::F_NONE);
        chk(rsp.ad_allow, 1'b1);
        r = br(eim_pkg::K_ACCESS, 6'h00);
        r.vapic_redirect = 1'b1;
        rq(r, eim_pkg::F_VMX_APIC);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        encl = '0;
        {encl.fs_ofs, encl.gs_ofs, encl.encl_base} = {64'h100, 64'h200, 64'h1000};
        {encl.fs_limit, encl.gs_limit, encl.encl_wide_mode_attribute} = {32'hfff, 32'h7ff, 1'b1};
        {encl.ssa_fs_base, encl.ssa_gs_base} = {64'h5000, 64'h6000};
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_feat();
        t_pfx();
        t_encl();
        t_vm();
        test_done();
    end
endmodule
`default_nettype wire
